// *** src/dpram_pkg.sv ***
// Shared constants and carrier types for the dual-port synchronous SRAM
package dpram_pkg;
  localparam int NPORTS = 2;
  localparam int ADDR_W = 14;
  localparam int DEPTH = 16384;
  localparam int DATA_W = 18;
  // Lane masks for the two data organisations
  localparam logic [DATA_W-1:0] LO_MASK_X18 = 18'h001FF;
  localparam logic [DATA_W-1:0] HI_MASK_X18 = 18'h3FE00;
  localparam logic [DATA_W-1:0] LO_MASK_X16 = 18'h000FF;
  localparam logic [DATA_W-1:0] HI_MASK_X16 = 18'h0FF00;
  // Register byte offsets
  localparam logic [31:0] CTRL_OFS = 32'h00000000;
  localparam logic [31:0] STAT_A_OFS = 32'h00000004;
  localparam logic [31:0] STAT_B_OFS = 32'h00000008;
  // Field positions and reset values
  localparam int CTRL_ORG_BIT = 0;
  localparam logic CTRL_ORG_RESET = 1'b1;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_PD_BIT = 16;
  localparam int STAT_MODE_BIT = 17;
  localparam int STAT_SEL_BIT = 18;
  localparam logic [ADDR_W-1:0] CNT_RESET = 14'h0000;
  localparam logic [ADDR_W-1:0] CNT_STEP = 14'h0001;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  // One port's pins as seen from outside
  typedef struct packed {
    logic port_clk;
    logic [ADDR_W-1:0] addr;
    logic addr_strobe_n;
    logic burst_count_en_n;
    logic burst_count_clr_n;
    logic chip_sel_low_n;
    logic chip_sel_high;
    logic low_lane_sel_n;
    logic high_lane_sel_n;
    logic out_en_n;
    logic read_not_write;
    logic flow_or_pipe_sel;
    logic [DATA_W-1:0] wdata;
  } port_pins_s;

  // Data pins driven by one port, with per-bit output enables
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] oe;
  } port_drive_s;
endpackage

// *** src/dpram_sync_top.sv ***
// Dual-port synchronous SRAM with burst counters and an AHB-Lite status/config port
// Operation
// - Lower lane is read or written only while its select is low; 9 or 8 bits wide.
// - Lower lane drives read data only when lane select and output enable are low.
// - Upper lane select gates the upper lane exactly like the lower one.
// - Data pins drive during reads only while output enable is low.
// - Read/write level low writes the array, high reads it.
// - Mode pin low selects flow-through output, high selects pipelined output.
// - Both ports access any location independently and at the same time.
// - Control, address and write data are captured on the port's rising clock.
// - Pipelined mode adds one output register stage; flow-through bypasses it.
// - A deselected cycle powers the port down.
// - Pipelined outputs return only after one selected cycle following a deselect.
// - Each port has a burst counter on its address register, loaded by strobe.
// - Counter enable low increments the counter on every port clock edge; here only on edges where the port is selected.
// - Counter spans the whole array and wraps to address zero.
// - Counter clear low clears the burst counter.
// - Internal write pulse is self-timed, independent of port clock high time.
// - Strobe low uses the external address and loads it into the counter.
// - Counter enable is ignored while strobe or clear is low.
// - Counter clear has top priority over strobe and enable.
// - Port is selected only with low chip select low and high chip select high.
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
module dpram_sync_top (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire dpram_pkg::port_pins_s pin_a_in,
  input wire dpram_pkg::port_pins_s pin_b_in,
  output dpram_pkg::port_drive_s drive_a_out,
  output dpram_pkg::port_drive_s drive_b_out,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out
);
  localparam int NP = dpram_pkg::NPORTS;
  localparam int AW = dpram_pkg::ADDR_W;
  localparam int DW = dpram_pkg::DATA_W;

  dpram_pkg::port_pins_s sync1_reg [NP];
  dpram_pkg::port_pins_s sync2_reg [NP];
  logic clk_prev_reg [NP];
  logic [AW-1:0] cnt_reg [NP];
  logic [DW-1:0] mem [dpram_pkg::DEPTH];
  logic [DW-1:0] flow_q_reg [NP];
  logic [DW-1:0] pipe_q_reg [NP];
  logic [DW-1:0] flow_lane_reg [NP];
  logic [DW-1:0] pipe_lane_reg [NP];
  logic pd_reg [NP];
  dpram_pkg::port_drive_s drive_reg [NP];
  logic org_x18_reg;
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;

  logic edge_w [NP];
  logic sel_w [NP];
  logic [AW-1:0] acc_addr_w [NP];
  logic [DW-1:0] lane_w [NP];
  logic [DW-1:0] lo_mask_w;
  logic [DW-1:0] hi_mask_w;
  logic [31:0] stat_w [NP];
  logic [31:0] rd_mux_w;
  logic addr_phase_w;

  // Pins come from the host's clock domain; every bit passes two flops first
  always_ff @(posedge clk_in) begin
    sync1_reg[0] <= pin_a_in;
    sync1_reg[1] <= pin_b_in;
    for (int p = 0; p < NP; p++) begin
      sync2_reg[p] <= sync1_reg[p];
    end
  end

  // Port clock edges are found on the synchronised copy, so data and clock stay aligned
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < NP; p++) begin
      if (!rstn_in) begin
        clk_prev_reg[p] <= 1'b0;
      end else begin
        clk_prev_reg[p] <= sync2_reg[p].port_clk;
      end
    end
  end

  always_comb begin
    lo_mask_w = org_x18_reg ? dpram_pkg::LO_MASK_X18 : dpram_pkg::LO_MASK_X16;
    hi_mask_w = org_x18_reg ? dpram_pkg::HI_MASK_X18 : dpram_pkg::HI_MASK_X16;
  end

  // Per-port decode of the synchronised pins
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      edge_w[p] = sync2_reg[p].port_clk & ~clk_prev_reg[p];
      sel_w[p] = ~sync2_reg[p].chip_sel_low_n & sync2_reg[p].chip_sel_high;
      lane_w[p] = (sync2_reg[p].low_lane_sel_n ? '0 : lo_mask_w) |
                  (sync2_reg[p].high_lane_sel_n ? '0 : hi_mask_w);
    end
  end

  // Access address: clear beats strobe, strobe beats enable
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      if (!sync2_reg[p].burst_count_clr_n) begin
        acc_addr_w[p] = dpram_pkg::CNT_RESET;
      end else if (!sync2_reg[p].addr_strobe_n) begin
        acc_addr_w[p] = sync2_reg[p].addr;
      end else if (!sync2_reg[p].burst_count_en_n) begin
        acc_addr_w[p] = cnt_reg[p] + dpram_pkg::CNT_STEP;
      end else begin
        acc_addr_w[p] = cnt_reg[p];
      end
    end
  end

  // Counter follows the access address; a deselected port keeps it unless cleared
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < NP; p++) begin
      if (!rstn_in) begin
        cnt_reg[p] <= dpram_pkg::CNT_RESET;
      end else if (edge_w[p]) begin
        if (!sync2_reg[p].burst_count_clr_n) begin
          cnt_reg[p] <= dpram_pkg::CNT_RESET;
        end else if (sel_w[p]) begin
          cnt_reg[p] <= acc_addr_w[p];
        end
      end
    end
  end

  // One clk_in cycle per port edge forms the write pulse, whatever the port clock duty.
  // Port B is applied last, so a same-location collision keeps B; hosts must not rely on it.
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < NP; p++) begin
      if (edge_w[p] && sel_w[p] && !sync2_reg[p].read_not_write) begin
        mem[acc_addr_w[p]] <= (mem[acc_addr_w[p]] & ~lane_w[p]) |
                              (sync2_reg[p].wdata & lane_w[p]);
      end
    end
  end

  // Read path: flow stage fed from the array on every port edge
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < NP; p++) begin
      if (!rstn_in) begin
        flow_q_reg[p] <= '0;
      end else if (edge_w[p]) begin
        flow_q_reg[p] <= mem[acc_addr_w[p]];
      end
    end
  end

  // Lanes that the read of this port edge may drive; a write or a deselect drives none
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < NP; p++) begin
      if (!rstn_in) begin
        flow_lane_reg[p] <= '0;
      end else if (edge_w[p]) begin
        flow_lane_reg[p] <= (sel_w[p] && sync2_reg[p].read_not_write) ? lane_w[p] : '0;
      end
    end
  end

  // Pipe stage: one port edge behind the flow stage
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < NP; p++) begin
      if (!rstn_in) begin
        pipe_q_reg[p] <= '0;
      end else if (edge_w[p]) begin
        pipe_q_reg[p] <= flow_q_reg[p];
      end
    end
  end

  // A deselected edge empties the pipe lanes, so outputs need one selected edge to come back
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < NP; p++) begin
      if (!rstn_in) begin
        pipe_lane_reg[p] <= '0;
      end else if (edge_w[p]) begin
        pipe_lane_reg[p] <= sel_w[p] ? flow_lane_reg[p] : '0;
      end
    end
  end

  // Power-down only gates the flow-through outputs; the array keeps its contents
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < NP; p++) begin
      if (!rstn_in) begin
        pd_reg[p] <= 1'b1;
      end else if (edge_w[p]) begin
        pd_reg[p] <= ~sel_w[p];
      end
    end
  end

  // Output enable pin acts on the held lanes between port edges, like an asynchronous enable
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < NP; p++) begin
      if (!rstn_in) begin
        drive_reg[p] <= '0;
      end else if (sync2_reg[p].flow_or_pipe_sel) begin
        drive_reg[p].data <= pipe_q_reg[p];
        drive_reg[p].oe <= sync2_reg[p].out_en_n ? '0 : pipe_lane_reg[p];
      end else begin
        drive_reg[p].data <= flow_q_reg[p];
        drive_reg[p].oe <= (sync2_reg[p].out_en_n || pd_reg[p]) ? '0 : flow_lane_reg[p];
      end
    end
  end

  assign drive_a_out = drive_reg[0];
  assign drive_b_out = drive_reg[1];

  // Bus slave: zero wait states, read data prepared at the end of the address phase
  assign addr_phase_w = hsel_in & htrans_in[1] & hready_in;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      stat_w[p] = '0;
      stat_w[p][dpram_pkg::STAT_CNT_LSB +: AW] = cnt_reg[p];
      stat_w[p][dpram_pkg::STAT_PD_BIT] = pd_reg[p];
      stat_w[p][dpram_pkg::STAT_MODE_BIT] = sync2_reg[p].flow_or_pipe_sel;
      stat_w[p][dpram_pkg::STAT_SEL_BIT] = sel_w[p];
    end
  end

  always_comb begin
    rd_mux_w = '0;
    if (haddr_in == dpram_pkg::CTRL_OFS) begin
      rd_mux_w[dpram_pkg::CTRL_ORG_BIT] = org_x18_reg;
    end else if (haddr_in == dpram_pkg::STAT_A_OFS) begin
      rd_mux_w = stat_w[0];
    end else if (haddr_in == dpram_pkg::STAT_B_OFS) begin
      rd_mux_w = stat_w[1];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wr_pend_reg <= 1'b0;
    end else if (hready_in) begin
      wr_pend_reg <= addr_phase_w & hwrite_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wr_addr_reg <= '0;
    end else if (hready_in) begin
      wr_addr_reg <= haddr_in;
    end
  end

  // Read data stands until the next read address phase
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      hrdata_reg <= dpram_pkg::RDATA_RESET;
    end else if (addr_phase_w && !hwrite_in) begin
      hrdata_reg <= rd_mux_w;
    end
  end

  // Organisation bit: steers lane widths of both ports
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      org_x18_reg <= dpram_pkg::CTRL_ORG_RESET;
    end else if (wr_pend_reg && wr_addr_reg == dpram_pkg::CTRL_OFS) begin
      org_x18_reg <= hwdata_in[dpram_pkg::CTRL_ORG_BIT];
    end
  end

  // Never stalls and never errors: every access completes with zero wait states
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      hreadyout_reg <= 1'b1;
    end else begin
      hreadyout_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      hresp_reg <= 1'b0;
    end else begin
      hresp_reg <= 1'b0;
    end
  end

  assign hrdata_out = hrdata_reg;
  assign hreadyout_out = hreadyout_reg;
  assign hresp_out = hresp_reg;
endmodule

// *** tb/dpram_sync_monitor.sv ***
// Concurrent checks on the dual-port SRAM top-level pins
`timescale 1ns/1ps
module dpram_sync_monitor (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire dpram_pkg::port_pins_s pin_a_in,
  input wire dpram_pkg::port_drive_s drive_a_out,
  input wire dpram_pkg::port_drive_s drive_b_out,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic rd_take;
  assign rd_take = hsel_in && htrans_in[1] && !hwrite_in;
  a_reset_quiet: assert property (disable iff (1'b0) !rstn_in |=> drive_a_out.oe == '0) else $error("reset drive");
  a_oe_pin_off: assert property (pin_a_in.out_en_n [*6] |-> drive_a_out.oe == '0) else $error("drive, oe high");
  // Lane selects are taken with the port edge, so look back two cycles; a rise caused by the
  // output enable pin re-drives lanes chosen at the last port edge and is left out here
  a_lo_lane_gate: assert property (
    $rose(drive_a_out.oe[0]) && $past(!pin_a_in.out_en_n, 4) |->
    $past(!pin_a_in.low_lane_sel_n, 2)) else $error("lo");
  a_hi_lane_gate: assert property (
    $rose(drive_a_out.oe[9]) && $past(!pin_a_in.out_en_n, 4) |->
    $past(!pin_a_in.high_lane_sel_n, 2)) else $error("hi");
  a_resp_okay: assert property (hresp_out == 1'b0) else $error("resp not okay");
  a_ready_high: assert property (hreadyout_out) else $error("ready low");
  a_rdata_stand: assert property (!rd_take |=> $stable(hrdata_out)) else $error("rdata moved");
  a_unmapped_zero: assert property (rd_take && haddr_in == 32'h10 |=> hrdata_out == 32'h0) else $error("unmapped");
  c_full_read: cover property (drive_a_out.oe == 18'h3FFFF);
  c_port_b_drive: cover property (drive_b_out.oe != '0);
  c_bus_write: cover property (hsel_in && htrans_in[1] && hwrite_in);
endmodule

// *** tb/port_host_model.sv ***
// Host logic driving one memory port, one port clock period per call
`timescale 1ns/1ps
module port_host (
  output dpram_pkg::port_pins_s pins_out
);
  initial begin
    pins_out = '0;
    pins_out.chip_sel_low_n = 1'b1;
  end
  // Both ports never write one address in one period; that result is undefined
  // c = {mode, select, read, strobe_n, count_en_n, clear_n, low_n, high_n, oe_n}
  task automatic cyc(input logic [8:0] c, input logic [13:0] a, input logic [17:0] d);
    #3;
    pins_out.flow_or_pipe_sel = c[8];
    {pins_out.chip_sel_low_n, pins_out.chip_sel_high} = {!c[7], c[7]};
    pins_out.read_not_write = c[6];
    {pins_out.addr_strobe_n, pins_out.burst_count_en_n, pins_out.burst_count_clr_n} = c[5:3];
    {pins_out.low_lane_sel_n, pins_out.high_lane_sel_n, pins_out.out_en_n} = c[2:0];
    pins_out.addr = a;
    // Released data lines toggle so a stale value never passes for a write
    pins_out.wdata = c[6] ? ~pins_out.wdata : d;
    // Port clock edges fall between system clock edges, so sampling never races the pin
    #36 pins_out.port_clk = 1'b1;
    #80 pins_out.port_clk = 1'b0;
    #41;
  endtask
endmodule

// *** tb/dpram_sync_top_tb_top.sv ***
// Self-checking bench for the dual-port synchronous SRAM
`timescale 1ns/1ps
module dpram_sync_top_tb_top;
  localparam logic [8:0] W_LD = 9'h099, W_INC = 9'h0A9, R_LD = 9'h0D8, R_INC = 9'h0E8, R_HOLD = 9'h0F8;
  localparam logic [8:0] PIPE = 9'h100;
  localparam logic [17:0] ALL = 18'h3FFFF;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hready, hresp;
  dpram_pkg::port_pins_s pin_a, pin_b;
  dpram_pkg::port_drive_s drv_a, drv_b;
  int err_total = 0;
  int check_count = 0;
  initial forever #5 clk_in = ~clk_in;
  port_host i_ha (.pins_out(pin_a));
  port_host i_hb (.pins_out(pin_b));
  dpram_sync_top i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .pin_a_in(pin_a), .pin_b_in(pin_b),
    .drive_a_out(drv_a), .drive_b_out(drv_b), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, wr};
    do @(posedge clk_in); while (hready !== 1'b1 && ++n < 50);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge clk_in); while (hready !== 1'b1 && ++n < 50);
    rd = hrdata;
    if (n >= 50) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic t_regs();
    ahb(1'b0, dpram_pkg::CTRL_OFS, 32'h0);
    chk(36'(rd), 36'h1);
    ahb(1'b1, dpram_pkg::CTRL_OFS, 32'h0);
    ahb(1'b0, dpram_pkg::CTRL_OFS, 32'h0);
    chk(36'(rd), 36'h0);
    ahb(1'b1, dpram_pkg::CTRL_OFS, 32'h1);
    ahb(1'b0, 32'h10, 32'h0);
    chk(36'(rd), 36'h0);
  endtask
  task automatic t_burst();
    i_ha.cyc(W_LD, 14'h3FFE, 18'h12345);
    i_ha.cyc(W_INC, 14'h0005, 18'h2A5A5);
    i_ha.cyc(W_INC, 14'h0005, 18'h3C3C3);
    i_ha.cyc(R_LD ^ 9'h010, 14'h3FFE, 18'h0);
    chk(drv_a, {18'h12345, ALL});
    i_ha.cyc(R_INC, 14'h0005, 18'h0);
    chk(drv_a, {18'h2A5A5, ALL});
    i_ha.cyc(R_INC, 14'h0005, 18'h0);
    chk(drv_a, {18'h3C3C3, ALL});
    i_ha.cyc(W_LD ^ 9'h002, 14'h3FFE, 18'h0);
    i_ha.cyc(R_LD, 14'h3FFE, 18'h0);
    chk(drv_a, {18'h12200, ALL});
    i_ha.cyc(R_LD ^ 9'h004, 14'h3FFE, 18'h0);
    chk(36'(drv_a.oe), 36'(dpram_pkg::HI_MASK_X18));
    i_ha.cyc(R_LD ^ 9'h001, 14'h3FFE, 18'h0);
    chk(36'(drv_a.oe), 36'h0);
    ahb(1'b1, dpram_pkg::CTRL_OFS, 32'h0);
    i_ha.cyc(R_LD ^ 9'h002, 14'h3FFE, 18'h0);
    chk(36'(drv_a.oe), 36'(dpram_pkg::LO_MASK_X16));
    ahb(1'b1, dpram_pkg::CTRL_OFS, 32'h1);
  endtask
  task automatic t_ports();
    fork
      i_ha.cyc(W_LD, 14'h0010, 18'h0ABCD);
      i_hb.cyc(R_LD | PIPE, 14'h3FFE, 18'h0);
    join
    chk(36'(drv_b.oe), 36'h0);
    i_hb.cyc(R_HOLD | PIPE, 14'h0000, 18'h0);
    chk(drv_b, {18'h12200, ALL});
    i_hb.cyc((R_HOLD | PIPE) ^ 9'h080, 14'h0000, 18'h0);
    chk(36'(drv_b.oe), 36'h0);
    i_hb.cyc(R_HOLD | PIPE, 14'h0000, 18'h0);
    chk(36'(drv_b.oe), 36'h0);
    i_hb.cyc(R_LD, 14'h0010, 18'h0);
    chk(drv_b, {18'h0ABCD, ALL});
    i_ha.cyc(W_LD ^ 9'h080, 14'h0010, 18'h11111);
    i_ha.cyc(R_LD ^ 9'h080, 14'h0020, 18'h0);
    chk(36'(drv_a.oe), 36'h0);
    ahb(1'b0, dpram_pkg::STAT_A_OFS, 32'h0);
    chk(36'(rd & 32'h00013FFF), 36'h10010);
    i_ha.cyc(R_LD, 14'h0010, 18'h0);
    chk(drv_a, {18'h0ABCD, ALL});
    i_ha.cyc(R_LD ^ 9'h018, 14'h1234, 18'h0);
    chk(drv_a, {18'h3C3C3, ALL});
    ahb(1'b0, dpram_pkg::STAT_A_OFS, 32'h0);
    chk(36'(rd & 32'h00003FFF), 36'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_regs();
    t_burst();
    t_ports();
    end_sim();
  end
  initial begin
    #50000;
    err_total++;
    end_sim();
  end
endmodule
bind dpram_sync_top dpram_sync_monitor i_mon (.clk_in(clk_in), .rstn_in(rstn_in), .pin_a_in(pin_a_in),
  .drive_a_out(drive_a_out), .drive_b_out(drive_b_out), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out));
